// >>> core/fps_flash_protect.sv
// flash program/erase protection and power-state control, ahb-lite slave
`timescale 1ns/1ps
module fps_flash_protect #(
  parameter int ERASE_BLOCKS  = 8,
  parameter int WAKE_TICK_CYC = fps_pkg::WAKE_TICK_CYC
) (
  // clock and resets
  input  wire logic                   clk,
  input  wire logic                   nrst,
  input  wire logic                   por_n,
  // ahb-lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic [31:0]                 hrdata,
  output logic                        hresp,
  // chip operating mode
  input  fps_pkg::fps_chip_mode_t     chip_mode,
  // cpu activity seen by the flash
  input  wire logic                   flash_read,
  input  wire logic                   exc_start,
  input  wire logic                   sleep_exec,
  // flash array controls
  output logic                        flash_prog_en,
  output logic                        flash_erase_en,
  output logic [ERASE_BLOCKS-1:0]     flash_erase_blk,
  output logic                        flash_pv_en,
  output logic                        flash_ev_en,
  output logic                        flash_powerdown,
  output logic                        flash_standby,
  output logic                        flash_ready,
  output logic                        flash_error_flag
);

  typedef struct packed {
    // flash_mode_ctrl_one
    logic                    prog_bit;
    logic                    erase_bit;
    logic                    pv_bit;
    logic                    ev_bit;
    logic                    software_write_enable;
    // erase_block_select
    logic [ERASE_BLOCKS-1:0] erase_blk;
    // flash_power_ctrl and system_ctrl_one
    logic                    subactive_powerdown_disable;
    logic [2:0]              wait_sel;
    // active modes toward the array
    logic                    prog_mode;
    logic                    erase_mode;
    logic                    pv_mode;
    logic                    ev_mode;
    logic [ERASE_BLOCKS-1:0] erase_blk_en;
    fps_pkg::fps_flash_state_t fl_state;
    logic                    pd_out;
    logic                    sb_out;
    // bus slave
    logic                    wr_pend;
    logic                    rd_pend;
    logic [7:0]              addr;
    logic                    ready_out;
    logic [31:0]             rdata;
  } fps_state_t;

  fps_state_t r;
  fps_state_t n;

  logic hw_prot;
  logic blocked;
  logic err_hit;
  logic err_flag;
  logic wake_busy;
  logic wake_start;
  logic op_busy;

  // register read mux; unmapped offsets read as zero
  function automatic logic [31:0] rd_mux(
    input logic [7:0]  addr,
    input fps_state_t  s,
    input logic        eflag,
    input logic        wbusy
  );
    logic [31:0] v;
    v = '0;
    unique case (addr)
      fps_pkg::ADDR_MODE_CTRL: begin
        v[fps_pkg::MC_PROG_BIT]  = s.prog_bit;
        v[fps_pkg::MC_ERASE_BIT] = s.erase_bit;
        v[fps_pkg::MC_PV_BIT]    = s.pv_bit;
        v[fps_pkg::MC_EV_BIT]    = s.ev_bit;
        v[fps_pkg::MC_SWE_BIT]   = s.software_write_enable;
      end
      fps_pkg::ADDR_ERR_CTRL: begin
        v[fps_pkg::ERR_FLAG_BIT] = eflag;
      end
      fps_pkg::ADDR_ERASE_BLK: begin
        v[ERASE_BLOCKS-1:0] = s.erase_blk;
      end
      fps_pkg::ADDR_PWR_CTRL: begin
        v[fps_pkg::PWR_SUBACTIVE_POWERDOWN_DISABLE_BIT] = s.subactive_powerdown_disable;
      end
      fps_pkg::ADDR_SYS_CTRL: begin
        v[fps_pkg::SYS_WAIT_LSB +: 3] = s.wait_sel;
      end
      fps_pkg::ADDR_STATUS: begin
        v[fps_pkg::ST_PROG_BIT]  = s.prog_mode;
        v[fps_pkg::ST_ERASE_BIT] = s.erase_mode;
        v[fps_pkg::ST_PV_BIT]    = s.pv_mode;
        v[fps_pkg::ST_EV_BIT]    = s.ev_mode;
        v[fps_pkg::ST_WAKE_BIT]  = wbusy;
        v[fps_pkg::ST_STATE_LSB +: 2] = 2'(s.fl_state);
      end
      default: begin
        v = '0;
      end
    endcase
    return v;
  endfunction

  // a program or erase is under way while either mode is live
  assign op_busy = r.prog_mode | r.erase_mode;

  // sticky violation flag lives in its own power-on domain
  fps_err_latch u_err (
    .clk        (clk),
    .por_n      (por_n),
    .op_busy    (op_busy),
    .flash_read (flash_read),
    .exc_start  (exc_start),
    .sleep_exec (sleep_exec),
    .err_hit    (err_hit),
    .err_flag   (err_flag)
  );

  // holds the array off after leaving power-down or standby
  fps_wake_timer #(
    .TICK_CYC (WAKE_TICK_CYC),
    .SEL_W    (fps_pkg::WAIT_SEL_W)
  ) u_wake (
    .clk      (clk),
    .nrst     (nrst),
    .start    (wake_start),
    .wait_sel (r.wait_sel),
    .busy     (wake_busy)
  );

  // next-state logic
  always_comb begin
    n = r;

    // modes that force program/erase off
    hw_prot = (chip_mode == fps_pkg::CHIP_SUBACTIVE) ||
              (chip_mode == fps_pkg::CHIP_SUBSLEEP)  ||
              (chip_mode == fps_pkg::CHIP_STANDBY);

    // bus: finish a pending read with one wait state
    n.wr_pend = 1'b0;
    n.rd_pend = 1'b0;
    if (r.rd_pend) begin
      n.rdata     = rd_mux(r.addr, r, err_flag, wake_busy);
      n.ready_out = 1'b1;
    end

    // bus: address phase; reads stall one cycle so data is never stale
    if (hsel && htrans[1] && hready) begin
      n.addr      = haddr[7:0];
      n.wr_pend   = hwrite;
      n.rd_pend   = !hwrite;
      n.ready_out = hwrite;
    end

    // bus: write data phase; hsize is not checked, words only
    if (r.wr_pend) begin
      unique case (r.addr)
        fps_pkg::ADDR_MODE_CTRL: begin
          n.software_write_enable    = hwdata[fps_pkg::MC_SWE_BIT];
          n.pv_bit = hwdata[fps_pkg::MC_PV_BIT];
          n.ev_bit = hwdata[fps_pkg::MC_EV_BIT];
          // setting is ignored without write enable; both at once is illegal
          n.prog_bit  = hwdata[fps_pkg::MC_PROG_BIT] & r.software_write_enable &
                        ~hwdata[fps_pkg::MC_ERASE_BIT];
          n.erase_bit = hwdata[fps_pkg::MC_ERASE_BIT] & r.software_write_enable &
                        ~hwdata[fps_pkg::MC_PROG_BIT];
        end
        fps_pkg::ADDR_ERASE_BLK: begin
          n.erase_blk = hwdata[ERASE_BLOCKS-1:0];
        end
        fps_pkg::ADDR_PWR_CTRL: begin
          n.subactive_powerdown_disable = hwdata[fps_pkg::PWR_SUBACTIVE_POWERDOWN_DISABLE_BIT];
        end
        fps_pkg::ADDR_SYS_CTRL: begin
          n.wait_sel = hwdata[fps_pkg::SYS_WAIT_LSB +: 3];
        end
        default: begin
          n.addr = r.addr; // error flag, status and holes are read-only
        end
      endcase
    end

    // clearing write enable drops a program or erase request still held in the bits
    if (!n.software_write_enable) begin
      n.prog_bit  = 1'b0;
      n.erase_bit = 1'b0;
    end

    // low-power entry reinitialises the controls; error flag survives
    if (hw_prot) begin
      n.prog_bit  = 1'b0;
      n.erase_bit = 1'b0;
      n.pv_bit    = 1'b0;
      n.ev_bit    = 1'b0;
      n.software_write_enable       = 1'b0;
      n.erase_blk = fps_pkg::RST_ERASE_BLK[ERASE_BLOCKS-1:0];
    end

    // flash power state from the chip mode
    unique case (chip_mode)
      fps_pkg::CHIP_ACTIVE,
      fps_pkg::CHIP_SLEEP: begin
        n.fl_state = fps_pkg::FL_NORMAL;
      end
      fps_pkg::CHIP_SUBACTIVE: begin
        // supply partly halted, reads still served
        n.fl_state = r.subactive_powerdown_disable ? fps_pkg::FL_NORMAL
                             : fps_pkg::FL_POWERDOWN;
      end
      fps_pkg::CHIP_SUBSLEEP,
      fps_pkg::CHIP_STANDBY: begin
        n.fl_state = fps_pkg::FL_STANDBY;
      end
      default: begin
        n.fl_state = fps_pkg::FL_STANDBY; // illegal code: safest state
      end
    endcase

    // decoded here so the state pins come straight from flops
    n.pd_out = (n.fl_state == fps_pkg::FL_POWERDOWN);
    n.sb_out = (n.fl_state == fps_pkg::FL_STANDBY);

    // return to normal starts the software-chosen wait
    wake_start = (r.fl_state != fps_pkg::FL_NORMAL) &&
                 (n.fl_state == fps_pkg::FL_NORMAL);

    // the error stops modes in the very edge that sets the flag
    blocked = err_flag | err_hit | hw_prot | wake_busy | wake_start |
              (n.fl_state != fps_pkg::FL_NORMAL);

    // modes follow their bits exactly while nothing blocks them
    n.prog_mode  = n.prog_bit & n.software_write_enable & ~blocked;
    n.erase_mode = n.erase_bit & n.software_write_enable & ~blocked;

    // verify stays open after an error; low power or a live program/erase closes it
    n.pv_mode = n.pv_bit & n.software_write_enable & ~hw_prot & ~n.prog_mode &
                ~n.erase_mode;
    n.ev_mode = n.ev_bit & n.software_write_enable & ~hw_prot & ~n.prog_mode &
                ~n.erase_mode;

    // only selected blocks see the erase; zero select erases nothing
    n.erase_blk_en = n.erase_mode ? n.erase_blk
                                  : '0;
  end

  // state register; the pin reset also protects
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r           <= '0;
      r.erase_blk <= fps_pkg::RST_ERASE_BLK[ERASE_BLOCKS-1:0];
      r.wait_sel  <= fps_pkg::RST_WAIT_SEL;
      r.subactive_powerdown_disable     <= fps_pkg::RST_SUBACTIVE_POWERDOWN_DISABLE;
      r.fl_state  <= fps_pkg::FL_NORMAL;
      r.ready_out <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // bus outputs; the response is always okay
  assign hreadyout = r.ready_out;
  assign hrdata    = r.rdata;
  assign hresp     = 1'b0;

  // array controls come straight from flops: the state register, the wake timer (ready, inverted busy) and the error latch
  assign flash_prog_en    = r.prog_mode;
  assign flash_erase_en   = r.erase_mode;
  assign flash_erase_blk  = r.erase_blk_en;
  assign flash_pv_en      = r.pv_mode;
  assign flash_ev_en      = r.ev_mode;
  assign flash_powerdown  = r.pd_out;
  assign flash_standby    = r.sb_out;
  assign flash_ready      = ~wake_busy;
  assign flash_error_flag = err_flag;

endmodule

// >>> core/fps_pkg.sv
// shared constants and types for the flash protection and power-state block
package fps_pkg;

  // clock and timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int WAKE_TICK_NS  = 4096;
  // unit of the wake-up wait, rounded up to whole cycles
  localparam int WAKE_TICK_CYC =
    (WAKE_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAIT_SEL_W    = 3;

  // register byte offsets
  localparam logic [7:0] ADDR_MODE_CTRL = 8'h00;
  localparam logic [7:0] ADDR_ERR_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_ERASE_BLK = 8'h08;
  localparam logic [7:0] ADDR_PWR_CTRL  = 8'h0c;
  localparam logic [7:0] ADDR_SYS_CTRL  = 8'h10;
  localparam logic [7:0] ADDR_STATUS    = 8'h14;

  // flash_mode_ctrl_one fields
  localparam int MC_PROG_BIT  = 0;
  localparam int MC_ERASE_BIT = 1;
  localparam int MC_PV_BIT    = 2;
  localparam int MC_EV_BIT    = 3;
  localparam int MC_SWE_BIT   = 6;
  // flash_error_ctrl_two field
  localparam int ERR_FLAG_BIT = 7;
  // flash_power_ctrl field
  localparam int PWR_SUBACTIVE_POWERDOWN_DISABLE_BIT = 7;
  // system_ctrl_one field
  localparam int SYS_WAIT_LSB = 4;
  // status fields
  localparam int ST_PROG_BIT  = 0;
  localparam int ST_ERASE_BIT = 1;
  localparam int ST_PV_BIT    = 2;
  localparam int ST_EV_BIT    = 3;
  localparam int ST_WAKE_BIT  = 4;
  localparam int ST_STATE_LSB = 5;

  // values after reset
  localparam logic [7:0] RST_ERASE_BLK = 8'h00;
  localparam logic [2:0] RST_WAIT_SEL  = 3'h0;
  localparam logic       RST_SUBACTIVE_POWERDOWN_DISABLE     = 1'b0;

  // chip operating modes
  typedef enum logic [2:0] {
    CHIP_ACTIVE,
    CHIP_SLEEP,
    CHIP_SUBACTIVE,
    CHIP_SUBSLEEP,
    CHIP_STANDBY
  } fps_chip_mode_t;

  // flash array power states
  typedef enum logic [1:0] {
    FL_NORMAL,
    FL_POWERDOWN,
    FL_STANDBY
  } fps_flash_state_t;

endpackage

// >>> core/fps_err_latch.sv
// sticky algorithm-violation flag, cleared only by power-on reset
`timescale 1ns/1ps
module fps_err_latch (
  // clock and power-on reset
  input  wire logic clk,
  input  wire logic por_n,
  // operation in progress
  input  wire logic op_busy,
  // cpu activity
  input  wire logic flash_read,
  input  wire logic exc_start,
  input  wire logic sleep_exec,
  // result
  output logic      err_hit,
  output logic      err_flag
);

  typedef struct packed {
    logic flag;
  } fps_err_t;

  fps_err_t r;
  fps_err_t n;

  // violation seen this cycle; feeds the abort without waiting a cycle
  always_comb begin
    err_hit = op_busy & (flash_read | exc_start | sleep_exec);
    n       = r;
    if (err_hit) begin
      n.flag = 1'b1;
    end
  end

  // pin reset is deliberately not a term here
  always_ff @(posedge clk) begin
    if (!por_n) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign err_flag = r.flag;

endmodule

// >>> core/fps_wake_timer.sv
// wake-up wait for the flash supply after power-down or standby
`timescale 1ns/1ps
module fps_wake_timer #(
  parameter int TICK_CYC = fps_pkg::WAKE_TICK_CYC,
  parameter int SEL_W    = fps_pkg::WAIT_SEL_W
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // control
  input  wire logic             start,
  input  wire logic [SEL_W-1:0] wait_sel,
  // status
  output logic                  busy
);

  localparam int DIV_W = $clog2(TICK_CYC + 1);

  typedef struct packed {
    logic             busy;
    logic [DIV_W-1:0] div;
    logic [SEL_W:0]   ticks;
  } fps_wake_t;

  fps_wake_t r;
  fps_wake_t n;
  logic      tick;

  // divider gives one enable per tick; wait is (wait_sel + 1) ticks
  always_comb begin
    n    = r;
    tick = (r.div == DIV_W'(TICK_CYC - 1));
    if (r.busy) begin
      n.div = tick ? '0 : r.div + 1'b1;
      if (tick) begin
        if (r.ticks == '0) begin
          n.busy = 1'b0;
        end else begin
          n.ticks = r.ticks - 1'b1;
        end
      end
    end
    // a restart during a wait begins a full new wait
    if (start) begin
      n.busy  = 1'b1;
      n.div   = '0;
      n.ticks = {1'b0, wait_sel};
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign busy = r.busy;

endmodule

// >>> tb/fps_flash_protect_monitor.sv
// port checker for the flash protection and power-state block
`timescale 1ns/1ps
module fps_flash_protect_monitor #(
  parameter int ERASE_BLOCKS  = 8,
  parameter int WAKE_TICK_CYC = 4
) (
  // clock and resets
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    por_n,
  // bus
  input wire logic                    hsel,
  input wire logic [1:0]              htrans,
  input wire logic                    hwrite,
  input wire logic                    hready,
  input wire logic                    hreadyout,
  input wire logic                    hresp,
  // chip and cpu activity
  input fps_pkg::fps_chip_mode_t      chip_mode,
  input wire logic                    flash_read,
  input wire logic                    exc_start,
  input wire logic                    sleep_exec,
  // array controls
  input wire logic                    flash_prog_en,
  input wire logic                    flash_erase_en,
  input wire logic [ERASE_BLOCKS-1:0] flash_erase_blk,
  input wire logic                    flash_pv_en,
  input wire logic                    flash_powerdown,
  input wire logic                    flash_standby,
  input wire logic                    flash_ready,
  input wire logic                    flash_error_flag
);
  // longest wake wait, wait select at its top value plus slack
  localparam int WAKE_MAX = 8 * WAKE_TICK_CYC + 3;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  chk_err_sticky: assert property (
    flash_error_flag && por_n |=> flash_error_flag) else $error("flag lost");
  chk_err_set: assert property (
    (flash_prog_en || flash_erase_en) && por_n
    && (flash_read || exc_start || sleep_exec) |=> flash_error_flag)
    else $error("violation missed");
  chk_err_abort: assert property (
    (flash_prog_en || flash_erase_en)
    && (flash_read || exc_start || sleep_exec)
    |=> !flash_prog_en && !flash_erase_en) else $error("mode not aborted");
  chk_no_reentry: assert property (
    flash_error_flag && por_n |=> !flash_prog_en && !flash_erase_en)
    else $error("mode under error");
  chk_hw_protect: assert property (
    chip_mode inside {fps_pkg::CHIP_SUBACTIVE, fps_pkg::CHIP_SUBSLEEP,
    fps_pkg::CHIP_STANDBY} |=> !flash_prog_en && !flash_erase_en
    && !flash_pv_en && flash_erase_blk == '0) else $error("no hw protect");
  chk_std_state: assert property (
    chip_mode inside {fps_pkg::CHIP_SUBSLEEP, fps_pkg::CHIP_STANDBY}
    |=> flash_standby && !flash_powerdown) else $error("not standby");
  chk_norm_state: assert property (
    chip_mode inside {fps_pkg::CHIP_ACTIVE, fps_pkg::CHIP_SLEEP}
    |=> !flash_standby && !flash_powerdown) else $error("not normal");
  chk_blk_gate: assert property (
    !flash_erase_en |-> flash_erase_blk == '0) else $error("blocks leak");
  chk_read_wait: assert property (
    hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait wrong");
  chk_resp_okay: assert property (hresp == 1'b0) else $error("resp not okay");
  chk_wake_len: assert property (
    $fell(flash_ready) |-> ##[1:WAKE_MAX] flash_ready)
    else $error("wake wait too long");
endmodule

bind fps_flash_protect fps_flash_protect_monitor #(
  .ERASE_BLOCKS(ERASE_BLOCKS), .WAKE_TICK_CYC(WAKE_TICK_CYC)) i_mon (
  .clk(clk), .nrst(nrst), .por_n(por_n), .hsel(hsel), .htrans(htrans),
  .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .chip_mode(chip_mode), .flash_read(flash_read), .exc_start(exc_start),
  .sleep_exec(sleep_exec), .flash_prog_en(flash_prog_en),
  .flash_erase_en(flash_erase_en), .flash_erase_blk(flash_erase_blk),
  .flash_pv_en(flash_pv_en), .flash_powerdown(flash_powerdown),
  .flash_standby(flash_standby), .flash_ready(flash_ready),
  .flash_error_flag(flash_error_flag));

// >>> tb/fps_testbench.sv
// self-checking bench for the flash protection and power-state block
`timescale 1ns/1ps
module testbench;
  localparam int          TICK = 4;
  localparam logic [31:0] SOFTWARE_WRITE_ENABLE  = 32'h1 << fps_pkg::MC_SWE_BIT;
  localparam logic [31:0] PRG  = 32'h1 << fps_pkg::MC_PROG_BIT;
  localparam logic [31:0] ERS  = 32'h1 << fps_pkg::MC_ERASE_BIT;
  localparam logic [31:0] PV   = 32'h1 << fps_pkg::MC_PV_BIT;
  localparam logic [31:0] EV   = 32'h1 << fps_pkg::MC_EV_BIT;
  logic        clk = 1'b0, nrst = 1'b0, por_n = 1'b0, hsel = 1'b0;
  logic        hwrite = 1'b0, flash_read = 1'b0, exc_start = 1'b0;
  logic        sleep_exec = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'd91037;
  fps_pkg::fps_chip_mode_t chip_mode = fps_pkg::CHIP_ACTIVE;
  logic        hreadyout, hresp, prog_en, erase_en, pv_en, ev_en;
  logic        pd, sb, ready, eflag, r;
  logic [7:0]  blk, sel;
  logic [2:0]  wsel;
  logic [31:0] hrdata, rdat;
  int          n;
  int          error_cnt = 0;
  int          tests_run = 0;

  // free-running clock, 4 ns period
  always #2 clk = ~clk;

  fps_flash_protect #(.ERASE_BLOCKS(8), .WAKE_TICK_CYC(TICK)) i_dut (
    .clk(clk), .nrst(nrst), .por_n(por_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .chip_mode(chip_mode), .flash_read(flash_read),
    .exc_start(exc_start), .sleep_exec(sleep_exec),
    .flash_prog_en(prog_en), .flash_erase_en(erase_en),
    .flash_erase_blk(blk), .flash_pv_en(pv_en), .flash_ev_en(ev_en),
    .flash_powerdown(pd), .flash_standby(sb), .flash_ready(ready),
    .flash_error_flag(eflag));

  // xorshift source, fixed start so runs repeat
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // expected flash state: 0 normal, 1 power-down, 2 standby
  function logic [1:0] exp_st(input fps_pkg::fps_chip_mode_t m, input logic d);
    if (m inside {fps_pkg::CHIP_SUBSLEEP, fps_pkg::CHIP_STANDBY}) return 2'h2;
    return (m == fps_pkg::CHIP_SUBACTIVE && !d) ? 2'h1 : 2'h0;
  endfunction

  task cmp_b(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, e, g);
    end
  endtask

  task cmp_w(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one single transfer; ready sampled at negedge, stable up to the edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    logic ok;
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    k = 0;
    do begin
      @(negedge clk);
      ok = hreadyout;
      @(posedge clk);
      k++;
    end while (ok !== 1'b1 && k < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    k = 0;
    do begin
      @(negedge clk);
      ok = hreadyout;
      rdat = hrdata;
      @(posedge clk);
      k++;
    end while (ok !== 1'b1 && k < 50);
    cmp_b("hready", 1'b1, ok);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    cmp_w("hrdata", e, rdat);
  endtask

  task final_report;
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    final_report;
  end

  initial begin
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    // reset values, unmapped words and the read-only flag
    for (int a = 0; a < 32; a += 4) rd(a[7:0], 32'h0);
    wr(8'h18, rnd());
    rd(8'h18, 32'h0);
    wr(fps_pkg::ADDR_ERR_CTRL, 32'h80);
    rd(fps_pkg::ADDR_ERR_CTRL, 32'h0);
    // program and erase refused without write-enable
    wr(fps_pkg::ADDR_MODE_CTRL, PRG | ERS);
    @(negedge clk);
    cmp_b("prog_en", 1'b0, prog_en);
    cmp_b("erase_en", 1'b0, erase_en);
    rd(fps_pkg::ADDR_MODE_CTRL, 32'h0);
    wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE);
    wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PRG);
    @(negedge clk);
    cmp_b("prog_en", 1'b1, prog_en);
    repeat (rnd() % 8) @(posedge clk);
    @(negedge clk);
    cmp_b("prog_en", 1'b1, prog_en);
    wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE);
    @(negedge clk);
    cmp_b("prog_en", 1'b0, prog_en);
    // erase masks: none, top block, random sets
    for (int i = 0; i < 5; i++) begin
      sel = (i == 0) ? 8'h00 : (i == 1) ? 8'h80 : 8'(rnd());
      wr(fps_pkg::ADDR_ERASE_BLK, {24'h0, sel});
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | ERS);
      @(negedge clk);
      cmp_b("erase_en", 1'b1, erase_en);
      cmp_w("erase_blk", {24'h0, sel}, {24'h0, blk});
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE);
      @(negedge clk);
      cmp_b("erase_en", 1'b0, erase_en);
    end
    // each violation kind during programming
    for (int k = 0; k < 3; k++) begin
      @(posedge clk);
      por_n <= 1'b0;
      @(posedge clk);
      por_n <= 1'b1;
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE);
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PRG);
      @(posedge clk);
      flash_read <= (k == 0);
      exc_start <= (k == 1);
      sleep_exec <= (k == 2);
      @(posedge clk);
      flash_read <= 1'b0;
      exc_start <= 1'b0;
      sleep_exec <= 1'b0;
      @(negedge clk);
      cmp_b("err_flag", 1'b1, eflag);
      cmp_b("prog_en", 1'b0, prog_en);
      rd(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PRG);
      rd(fps_pkg::ADDR_ERR_CTRL, 32'h80);
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE);
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PRG);
      @(negedge clk);
      cmp_b("prog_en", 1'b0, prog_en);
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PV);
      @(negedge clk);
      cmp_b("pv_en", 1'b1, pv_en);
    end
    wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | EV);
    @(negedge clk);
    cmp_b("ev_en", 1'b1, ev_en);
    // pin reset keeps the flag, power-on reset clears it
    @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    cmp_b("err_flag", 1'b1, eflag);
    rd(fps_pkg::ADDR_MODE_CTRL, 32'h0);
    @(posedge clk);
    por_n <= 1'b0;
    @(posedge clk);
    por_n <= 1'b1;
    @(negedge clk);
    cmp_b("err_flag", 1'b0, eflag);
    // every chip mode with both power-down settings, then wake-up
    for (int d = 0; d < 2; d++) begin
      // software must never pick a wait shorter than four ticks
      wsel = 3'(4 + rnd() % 4);
      wr(fps_pkg::ADDR_PWR_CTRL, {24'h0, d[0], 7'h0});
      wr(fps_pkg::ADDR_SYS_CTRL, {25'h0, wsel, 4'h0});
      wr(fps_pkg::ADDR_ERASE_BLK, 32'hff);
      wr(fps_pkg::ADDR_MODE_CTRL, SOFTWARE_WRITE_ENABLE | PV);
      for (int m = 0; m < 5; m++) begin
        @(posedge clk);
        chip_mode <= fps_pkg::fps_chip_mode_t'(m);
        @(posedge clk);
        @(negedge clk);
        cmp_b("powerdown", exp_st(chip_mode, d[0]) == 2'h1, pd);
        cmp_b("standby", exp_st(chip_mode, d[0]) == 2'h2, sb);
      end
      rd(fps_pkg::ADDR_MODE_CTRL, 32'h0);
      rd(fps_pkg::ADDR_ERASE_BLK, 32'h0);
      rd(fps_pkg::ADDR_STATUS, 32'h2 << fps_pkg::ST_STATE_LSB);
      @(posedge clk);
      chip_mode <= fps_pkg::CHIP_ACTIVE;
      @(posedge clk);
      n = 0;
      do begin
        @(negedge clk);
        r = ready;
        @(posedge clk);
        n++;
      end while (r !== 1'b1 && n < 200);
      cmp_b("wake_len", 1'b1, n >= (wsel + 1) * TICK
            && n <= (wsel + 1) * TICK + 3);
    end
    final_report;
  end
endmodule
